/* File: hw/sdm_consts.vh */
// Constants for the serial DMA bus-master block
// Summary of operation
// - Fourteen channels: eight serial, six secondary/SPI
// - Each channel fixed to one direction
// - External target needs both buses; internal one
// - Per-channel function code, one of sixteen
// - Per-channel big or little endian order
// - Bus error sets event, captures address
// - Bus error halts processor until reset command
// - All channels share one arbitration ID
// - One operand, up to a long word, per bus tenure
// - Characters written singly; reads always long
// - Narrow port splits operand into cycles
// - Whole operand moved back to back
// - Yield to higher master, then resume
// - No arbitration overhead unless core enabled and an external master holds the bus
// - External request/grant pins left untouched
// - Bus clear asserted on request when enabled
// - Bus clear only if ID above threshold
// - Bus clear negated during memory access
// - Programmable priority; steal from independent DMA
// - Slave mode still steals from independent DMA
// - ID zero lowest, seven highest
// - Status bits sticky, write one clears
// - Service level above mask withholds request
// - Error address read-only 32-bit
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH
`define SDM_NUM_CH 14
`define SDM_CH_W 4
`define SDM_ADDR_CFG 4'h0
`define SDM_ADDR_STAT 4'h1
`define SDM_ADDR_ERRA 4'h2
`define SDM_ADDR_CMD 4'h3
`define SDM_ADDR_CHFC 4'h4
`define SDM_CFG_RESET 16'h0000
`define SDM_CFG_SISM_LSB 8
`define SDM_CFG_SAID_LSB 4
`define SDM_CFG_FRZ_LSB 13
`define SDM_CFG_INTE 1
`define SDM_CFG_INTB 0
`define SDM_STAT_SBER 1
`define SDM_STAT_SBKP 0
`define SDM_STAT_RINT 2
`define SDM_CMD_RESET 0
`define SDM_SIZE_BYTE 2'h1
`define SDM_SIZE_WORD 2'h2
`define SDM_SIZE_LONG 2'h0
`define SDM_PORT_8 2'h1
`define SDM_PORT_16 2'h2
`define SDM_PORT_32 2'h0
`endif

/* File: hw/sdm_serial_dma.v */
// Serial DMA bus master: arbitration, operand sequencing, errors
`include "sdm_consts.vh"
module sdm_serial_dma
(
   input wire clock,
   input wire rst,
   input wire clk_en,
   // Register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Per-channel requests from the serial controllers, fixed direction
   input wire [13:0] ch_req,
   input wire [13:0] ch_is_rx,
   input wire [13:0] ch_ext,
   input wire [31:0] ch_addr_flat,
   input wire [1:0] ch_size,
   input wire [31:0] ch_wdata,
   output wire [13:0] ch_ack,
   output reg [31:0] ch_rdata,
   // Internal module bus arbitration
   input wire [2:0] other_id,
   input wire other_req,
   input wire independent_dma_master,
   input wire [2:0] independent_dma_id,
   input wire [2:0] int_service_level,
   input wire ext_master_holds,
   input wire ext_bus_avail,
   input wire core_enabled,
   input wire show_cycles,
   output wire bus_req,
   output wire steal,
   // Bus cycle
   output reg cyc_valid,
   output reg [31:0] cyc_addr,
   output reg [31:0] cyc_wdata,
   output reg cyc_write,
   output reg [3:0] cyc_fc,
   output reg cyc_ext,
   output reg cyc_show,
   input wire cyc_done,
   input wire cyc_berr,
   input wire [1:0] cyc_port,
   input wire [31:0] cyc_rdata,
   input wire breakpoint,
   // Bus clear
   input wire bus_clear_enable,
   input wire [2:0] bus_clear_threshold_id,
   output reg bus_clear_out,
   output wire communication_processor_halted
);

   // ----------------------------------------------------------
   // Synchronisers for pin-level inputs
   // ----------------------------------------------------------
   reg ext_hold_s1_q;
   reg ext_hold_q;
   reg brk_s1_q;
   reg brk_q;
   // Two-flop capture of external-master hold and breakpoint
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ext_hold_s1_q <= 1'b0;
         ext_hold_q <= 1'b0;
         brk_s1_q <= 1'b0;
         brk_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ext_hold_s1_q <= ext_master_holds;
         ext_hold_q <= ext_hold_s1_q;
         brk_s1_q <= breakpoint;
         brk_q <= brk_s1_q;
      end
   end

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   reg [15:0] cfg_q;         // Configuration
   reg [2:0] stat_q;         // Sticky events
   reg [31:0] err_addr_q;    // Faulting address
   reg halt_q;               // Processor halted
   reg [3:0] fc_mem_q [0:13]; // Per-channel function code
   reg endian_mem_q [0:13];  // Per-channel little endian
   wire [2:0] said = cfg_q[`SDM_CFG_SAID_LSB+2:`SDM_CFG_SAID_LSB];
   wire [2:0] sism = cfg_q[`SDM_CFG_SISM_LSB+2:`SDM_CFG_SISM_LSB];
   wire freeze_sel = cfg_q[`SDM_CFG_FRZ_LSB+1];

   // ----------------------------------------------------------
   // State machine
   // ----------------------------------------------------------
   localparam ST_IDLE = 4'b0001;
   localparam ST_ARB = 4'b0010;
   localparam ST_CYC = 4'b0100;
   localparam ST_YIELD = 4'b1000;
   reg [3:0] state_q;
   reg [3:0] ch_q;           // Channel in service
   reg [31:0] addr_q;        // Next byte address
   reg [31:0] data_q;        // Operand being moved
   reg [2:0] left_q;         // Bytes outstanding
   reg write_q;
   reg [13:0] ack_q;

   // Picks lowest pending channel
   function [3:0] pick;
      input [13:0] r;
      integer i;
      begin
         pick = 4'h0;
         for (i = 13; i >= 0; i = i - 1)
            if (r[i])
               pick = i[3:0];
      end
   endfunction

   // Bytes a port moves per cycle
   function [2:0] port_bytes;
      input [1:0] p;
      begin
         case (p)
            `SDM_PORT_8: port_bytes = 3'h1;
            `SDM_PORT_16: port_bytes = 3'h2;
            default: port_bytes = 3'h4;
         endcase
      end
   endfunction

   // Bytes in an operand
   function [2:0] op_bytes;
      input [1:0] s;
      input w;
      begin
         if (!w)
            op_bytes = 3'h4;
         else if (s == `SDM_SIZE_BYTE)
            op_bytes = 3'h1;
         else if (s == `SDM_SIZE_WORD)
            op_bytes = 3'h2;
         else
            op_bytes = 3'h4;
      end
   endfunction

   // Byte swap for little-endian channels
   function [31:0] swap;
      input [31:0] d;
      input le;
      begin
         swap = le ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      end
   endfunction

   // ----------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------
   wire any_req = |ch_req;
   wire svc_block = int_service_level > sism;
   // higher id wins; one shared id
   wire higher_other = other_req && (other_id > said);
   wire want = !halt_q && !svc_block && !freeze_sel &&
      (state_q != ST_IDLE || any_req);
   // external target also needs the external bus
   wire bus_ok = !higher_other && (!cyc_ext || ext_bus_avail);
   // no overhead when nobody holds the external bus
   wire fast = (core_enabled ? !ext_hold_q : 1'b1);
   assign bus_req = want;
   // steal cycles from a lower independent DMA
   assign steal = want && independent_dma_master &&
      (said > independent_dma_id);
   // external request/grant pins are not driven here
   assign ch_ack = ack_q;
   assign communication_processor_halted = halt_q;

   wire [2:0] step = port_bytes(cyc_port);
   wire [2:0] take = (step > left_q) ? left_q : step;
   // Only the lanes a narrow port drives carry read data
   wire [31:0] rd_mask = (take == 3'h1) ? 32'h000000ff :
      (take == 3'h2) ? 32'h0000ffff : 32'hffffffff;

   // Main sequencer
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         ch_q <= 4'h0;
         addr_q <= 32'h0;
         data_q <= 32'h0;
         left_q <= 3'h0;
         write_q <= 1'b0;
         ack_q <= 14'h0;
         cyc_valid <= 1'b0;
         cyc_addr <= 32'h0;
         cyc_wdata <= 32'h0;
         cyc_write <= 1'b0;
         cyc_fc <= 4'h0;
         cyc_ext <= 1'b0;
         cyc_show <= 1'b0;
         ch_rdata <= 32'h0;
         halt_q <= 1'b0;
         err_addr_q <= 32'h0;
      end
      else if (clk_en)
      begin
         ack_q <= 14'h0;
         if (reg_wr && reg_addr == `SDM_ADDR_CMD &&
            reg_wdata[`SDM_CMD_RESET])
         begin
            // only the reset command clears the halt
            halt_q <= 1'b0;
            state_q <= ST_IDLE;
            cyc_valid <= 1'b0;
         end
         else
         case (state_q)
            ST_IDLE:
            begin
               if (want)
               begin
                  // channel picks its own fixed direction
                  ch_q <= pick(ch_req);
                  write_q <= ch_is_rx[pick(ch_req)];
                  addr_q <= ch_addr_flat;
                  data_q <= swap(ch_wdata, endian_mem_q[pick(ch_req)]);
                  left_q <= op_bytes(ch_size, ch_is_rx[pick(ch_req)]);
                  cyc_ext <= ch_ext[pick(ch_req)];
                  state_q <= ST_ARB;
               end
            end
            ST_ARB:
            begin
               if (!want)
                  state_q <= ST_YIELD;
               else if (bus_ok && fast)
               begin
                  cyc_valid <= 1'b1;
                  cyc_addr <= addr_q;
                  cyc_wdata <= data_q;
                  cyc_write <= write_q;
                  cyc_fc <= fc_mem_q[ch_q];
                  // internal access visible only in show mode
                  cyc_show <= !cyc_ext && show_cycles;
                  state_q <= ST_CYC;
               end
            end
            ST_CYC:
            begin
               if (cyc_berr)
               begin
                  err_addr_q <= cyc_addr;
                  halt_q <= 1'b1;
                  cyc_valid <= 1'b0;
                  state_q <= ST_IDLE;
               end
               else if (cyc_done)
               begin
                  cyc_valid <= 1'b0;
                  addr_q <= addr_q + {29'h0, take};
                  data_q <= write_q ? (data_q << {take, 3'h0}) :
                     ((data_q << {take, 3'h0}) |
                     (cyc_rdata & rd_mask));
                  left_q <= left_q - take;
                  if (left_q == take)
                  begin
                     ack_q[ch_q] <= 1'b1;
                     // reassembled operand goes to the channel
                     ch_rdata <= swap((data_q << {take, 3'h0}) |
                        (cyc_rdata & rd_mask), endian_mem_q[ch_q]);
                     state_q <= ST_IDLE;
                  end
                  // continue back to back unless preempted
                  else if (higher_other || !want)
                     state_q <= ST_YIELD;
                  else
                     state_q <= ST_ARB;
               end
            end
            ST_YIELD:
            begin
               // rearbitrate once the other master leaves
               if (!higher_other && want)
                  state_q <= ST_ARB;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Bus clear output
   // ----------------------------------------------------------
   // Drives bus clear from request and threshold
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         bus_clear_out <= 1'b0;
      else if (clk_en)
         // request, id above threshold, not accessing
         bus_clear_out <= bus_clear_enable && want &&
            (said > bus_clear_threshold_id) && state_q != ST_CYC;
   end

   // ----------------------------------------------------------
   // Register writes and status
   // ----------------------------------------------------------
   integer k;
   // Configuration, status and function code storage
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cfg_q <= `SDM_CFG_RESET;
         stat_q <= 3'h0;
         for (k = 0; k < `SDM_NUM_CH; k = k + 1)
         begin
            fc_mem_q[k] <= 4'h0;
            endian_mem_q[k] <= 1'b0;
         end
      end
      else if (clk_en)
      begin
         if (reg_wr && reg_addr == `SDM_ADDR_CFG)
            cfg_q <= reg_wdata[15:0] & 16'h6773;
         if (reg_wr && reg_addr == `SDM_ADDR_CHFC &&
            reg_wdata[11:8] < 4'he)
         begin
            // endian bit beside the function code
            fc_mem_q[reg_wdata[11:8]] <= reg_wdata[3:0];
            endian_mem_q[reg_wdata[11:8]] <= reg_wdata[4];
         end
         // write one clears, event set wins
         stat_q <= (stat_q & ~((reg_wr && reg_addr == `SDM_ADDR_STAT) ?
            reg_wdata[2:0] : 3'h0)) |
            {1'b0, (state_q == ST_CYC && cyc_berr),
            (state_q == ST_CYC && brk_q)};
      end
   end

   // ----------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------
   // Registered read mux
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         reg_rdata <= 32'h0;
      else if (clk_en)
      begin
         reg_rdata <= 32'h0;
         if (reg_rd)
            case (reg_addr)
               `SDM_ADDR_CFG: reg_rdata <= {16'h0, cfg_q};
               `SDM_ADDR_STAT: reg_rdata <= {29'h0, stat_q};
               `SDM_ADDR_ERRA: reg_rdata <= err_addr_q;
               `SDM_ADDR_CMD: reg_rdata <= {31'h0, halt_q};
               default: reg_rdata <= 32'h0;
            endcase
      end
   end

endmodule // sdm_serial_dma

/* File: verification/sdm_serial_dma_assertions.sv */
// Property checker for the serial DMA bus master
module sdm_serial_dma_checker
(
   input wire clock,
   input wire rst,
   input wire clk_en,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire [13:0] ch_ack,
   input wire bus_req,
   input wire cyc_valid,
   input wire cyc_done,
   input wire cyc_berr,
   input wire [2:0] int_service_level,
   input wire [2:0] bus_clear_threshold_id,
   input wire bus_clear_out,
   input wire communication_processor_halted
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Shadow of the configuration fields
   // ----------------------------------------
   logic [2:0] sism_q; // Service mask copy
   logic [2:0] said_q; // Arbitration ID copy
   logic halt_clr; // Processor reset command
   assign halt_clr = reg_wr && reg_addr == 4'h3 && reg_wdata[0];
   // Follow writes to the configuration word
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         sism_q <= 3'h0;
         said_q <= 3'h0;
      end
      else if (clk_en && reg_wr && reg_addr == 4'h0)
      begin
         sism_q <= reg_wdata[10:8];
         said_q <= reg_wdata[6:4];
      end
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   a_ack_single: assert property ($onehot0(ch_ack))
      else $error("two channels acknowledged");
   a_ack_cause: assert property
      (|ch_ack |-> $past(cyc_valid && cyc_done))
      else $error("ack without a finished cycle");
   a_cycle_holds: assert property
      (cyc_valid && !cyc_done && !cyc_berr && clk_en |=> cyc_valid)
      else $error("bus cycle dropped early");
   a_clear_above: assert property
      (bus_clear_out |-> $past(said_q > bus_clear_threshold_id))
      else $error("bus clear at or below threshold");
   a_clear_access: assert property
      (cyc_valid && $past(cyc_valid) |-> !bus_clear_out)
      else $error("bus clear during access");
   a_error_halts: assert property
      (cyc_valid && cyc_berr && clk_en
         |-> ##[1:2] communication_processor_halted)
      else $error("bus error did not halt");
   a_halt_sticky: assert property
      (communication_processor_halted && clk_en && !halt_clr
         |=> communication_processor_halted)
      else $error("halt released without command");
   a_halt_quiet: assert property
      (communication_processor_halted |-> !bus_req)
      else $error("request while halted");
   a_mask_hold: assert property
      (int_service_level > sism_q |-> !bus_req)
      else $error("request above service mask");
endmodule // sdm_serial_dma_checker

bind sdm_serial_dma sdm_serial_dma_checker chk_u (.*);

/* File: verification/sdm_bus_model.sv */
// Bus partner that answers serial DMA bus cycles
module sdm_bus_model
(
   input wire clock,
   input wire rst,
   input wire cyc_valid,
   input wire [31:0] cyc_addr,
   input wire cyc_write,
   input wire slow,
   input wire berr_on,
   output logic cyc_done,
   output logic cyc_berr,
   output logic [31:0] cyc_rdata,
   output int ncyc,
   output logic last_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q; // Wait states spent
   // One answer per cycle, after zero or two wait states
   always @(posedge clock or posedge rst)
      if (rst)
      begin
         cyc_done <= 1'b0;
         cyc_berr <= 1'b0;
         cyc_rdata <= 32'h0;
         ncyc <= 0;
         wait_q <= 2'h0;
         last_wr <= 1'b0;
      end
      else
      begin
         cyc_done <= 1'b0;
         cyc_berr <= 1'b0;
         // Data lines are not held between answers
         cyc_rdata <= ~cyc_rdata;
         if (cyc_valid && !cyc_done && !cyc_berr)
            if (slow && wait_q != 2'h2)
               wait_q <= wait_q + 2'h1;
            else
            begin
               wait_q <= 2'h0;
               cyc_done <= !berr_on;
               cyc_berr <= berr_on;
               cyc_rdata <= cyc_addr ^ 32'h3c5aa5c3;
               ncyc <= ncyc + 1;
               last_wr <= cyc_write;
            end
      end
endmodule // sdm_bus_model

/* File: verification/tb_serial_dma_bus_master.sv */
// Self-checking bench for the serial DMA bus master
`include "sdm_consts.vh"
module tb_serial_dma_bus_master;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0;
   logic reg_rd = 1'b0, other_req = 1'b0, independent_dma_master = 1'b0;
   logic ext_master_holds = 1'b0, ext_bus_avail = 1'b1, breakpoint = 1'b0;
   logic core_enabled = 1'b1, show_cycles = 1'b0, bus_clear_enable = 1'b0;
   logic slow = 1'b0, berr_on = 1'b0, rx, got, bco_seen, stl_seen;
   logic seen_ext, seen_show;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, ch_addr_flat = 32'h0, ch_wdata = 32'h0;
   logic [13:0] ch_req = 14'h0, ch_is_rx = 14'h0, ch_ext = 14'h0;
   logic [2:0] other_id = 3'h0, independent_dma_id = 3'h0;
   logic [2:0] int_service_level = 3'h0, bus_clear_threshold_id = 3'h7;
   logic [1:0] ch_size = 2'h0, cyc_port = 2'h0;
   logic [31:0] reg_rdata, ch_rdata, cyc_addr, cyc_wdata, cyc_rdata, rv, a;
   logic [31:0] seen_wd, e;
   logic [13:0] ch_ack;
   logic [3:0] cyc_fc, seen_fc;
   logic bus_req, steal, cyc_valid, cyc_write, cyc_ext, cyc_show;
   logic cyc_done, cyc_berr, bus_clear_out, communication_processor_halted;
   logic last_wr;
   int error_cnt = 0, checked = 0, ncyc, n0, c;
   sdm_serial_dma dut_u (.*);
   sdm_bus_model bus_u (.*);
   always #4 clock = ~clock;
   // Remember bus clear and steal, and what each finished cycle carried
   always @(posedge clock)
   begin
      if (bus_clear_out)
         bco_seen <= 1'b1;
      if (steal)
         stl_seen <= 1'b1;
      if (cyc_valid && cyc_done)
      begin
         seen_fc <= cyc_fc;
         seen_ext <= cyc_ext;
         seen_show <= cyc_show;
         seen_wd <= cyc_wdata;
      end
   end
   // outside logic halts the external master on bus clear
   always @(posedge clock)
      if (bus_clear_out)
         ext_master_holds <= 1'b0;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] g,
      input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad);
      @(posedge clock);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic start(input int ch, input logic [31:0] ad);
      @(posedge clock);
      ch_addr_flat <= ad;
      ch_is_rx[ch] <= rx;
      ch_req[ch] <= 1'b1;
   endtask
   // Wait for the acknowledge, then drop the request
   task automatic wack(input int ch, input int lim);
      got = 1'b0;
      repeat (lim)
         if (!got)
         begin
            @(posedge clock);
            #1 got = |ch_ack;
         end
      if (got)
      begin
         ch_req[ch] <= 1'b0;
         chk("ack", {18'h0, ch_ack}, 32'h1 << ch);
      end
   endtask
   function automatic logic [31:0] mem(input logic [31:0] ad);
      return ad ^ 32'h3c5aa5c3;
   endfunction
   // Byte order of a long word as a little-endian channel sees it
   function automatic logic [31:0] bsw(input logic [31:0] d, input logic le);
      return le ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles needed
   initial
   begin
      #160000;
      error_cnt++;
      close_out();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rv = $urandom(32'h97d0037f);
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd(`SDM_ADDR_STAT);
      chk("stat", rv, 32'h0);
      wr(`SDM_ADDR_CFG, 32'h0740);
      wr(4'h9, 32'hffff);
      rd(`SDM_ADDR_CFG);
      chk("cfg", rv, 32'h0740);
      // Function code is channel xor a, odd channels little endian
      for (int i = 0; i < 14; i++)
         wr(`SDM_ADDR_CHFC, {20'h0, i[3:0], 3'h0, i[0], i[3:0] ^ 4'ha});
      $display("test registers done");
      for (int i = 0; i < 24; i++)
      begin
         c = $urandom_range(13);
         a = $urandom & 32'hfffffffc;
         rx = $urandom_range(1);
         ch_size <= $urandom_range(2);
         ch_ext <= $urandom;
         ch_wdata <= $urandom;
         show_cycles <= $urandom;
         slow <= $urandom;
         n0 = ncyc;
         start(c, a);
         wack(c, 60);
         chk("done", got, 1);
         chk("cycles", ncyc - n0, 1);
         chk("dir", last_wr, rx);
         chk("fc", seen_fc, c[3:0] ^ 4'ha);
         chk("ext", seen_ext, ch_ext[c]);
         chk("show", seen_show, !ch_ext[c] && show_cycles);
         chk("wdata", seen_wd, bsw(ch_wdata, c[0]));
         if (!rx)
            chk("rdata", ch_rdata, bsw(mem(a), c[0]));
      end
      $display("test random transfers done");
      rx = 1'b0;
      for (int p = 1; p < 3; p++)
      begin
         cyc_port <= p[1:0];
         n0 = ncyc;
         start(2, 32'h100);
         wack(2, 100);
         chk("narrow", ncyc - n0, p == 1 ? 4 : 2);
         e = 32'h0;
         for (int k = 0; k < 4; k += p)
            e = (e << (8 * p)) |
               (mem(32'h100 + k) & ((32'h1 << (8 * p)) - 1));
         chk("assembled", ch_rdata, e);
      end
      cyc_port <= `SDM_PORT_32;
      $display("test narrow ports done");
      wr(`SDM_ADDR_CFG, 32'h0340);
      int_service_level <= 3'h5;
      start(5, 32'h200);
      wack(5, 30);
      chk("withheld", got, 0);
      int_service_level <= 3'h3;
      wack(5, 60);
      chk("resumed", got, 1);
      $display("test service mask done");
      bus_clear_enable <= 1'b1;
      independent_dma_master <= 1'b1;
      for (int t = 3; t < 5; t++)
      begin
         bus_clear_threshold_id <= t[2:0];
         independent_dma_id <= t[2:0];
         // Only the first pass has an external master to evict
         ext_master_holds <= (t == 3);
         bco_seen = 1'b0;
         stl_seen = 1'b0;
         start(1, 32'h300);
         wack(1, 60);
         chk("bus clear", bco_seen, t == 3);
         chk("steal", stl_seen, t == 3);
         chk("evicted", got, 1);
      end
      independent_dma_master <= 1'b0;
      $display("test bus clear done");
      berr_on <= 1'b1;
      start(7, 32'h4444);
      repeat (10) @(posedge clock);
      berr_on <= 1'b0;
      rd(`SDM_ADDR_STAT);
      chk("berr flag", rv[1], 1);
      rd(`SDM_ADDR_ERRA);
      chk("err addr", rv, 32'h4444);
      chk("halted", communication_processor_halted, 1);
      wack(7, 20);
      chk("no ack", got, 0);
      wr(`SDM_ADDR_STAT, 32'h2);
      rd(`SDM_ADDR_STAT);
      chk("berr clear", rv[1], 0);
      wr(`SDM_ADDR_CMD, 32'h1);
      wack(7, 60);
      chk("restart", got, 1);
      $display("test bus error done");
      close_out();
   end
endmodule // tb_serial_dma_bus_master
